// ==== design/wdi_watchdog_unit.sv ====
// Purpose: Watchdog and interval timer with keyed register writes
// Assumes: rst is the hardware clear pin, synchronous, active high
// Notes:   chip_r is the one reset request for pin and watchdog
`timescale 1ns/1ps
// Overview of operation
// - Watchdog overflow holds internal reset 518 states
// - Enabled external reset pin driven 132 states
// - Out-enable bit gates external reset pin
// - Watchdog and pin reset share one request
// - Pin reset wins over watchdog reset
// - Overflow in watchdog mode sets cause flag
// - Cause flag only with mode and run
// - Internal reset clears overflow, keeps cause
// - Interval mode requests interrupt per overflow
// - Overflow flag set on the overflow cycle
// - Interval request follows overflow flag
// - Counter write beats same-cycle increment
// - Counter increments on tick, wraps FF to 00
// - Clearing run halts and zeroes counter
// - Select picks one of eight divisors
// - Keyed word writes only, byte writes ignored
module wdi_watchdog_unit (
  // Clock, pin reset and clock enable
  input  logic        clk_sys,
  input  logic        rst,
  input  logic        ce,
  // CPU write port
  input  logic        cpu_wr,
  input  logic        cpu_wr_word,
  input  logic        cpu_wr_rst_reg,
  input  logic [15:0] cpu_wdata,
  // CPU read of the control byte, arms the flag clear
  input  logic        cpu_rd_ctrl,
  // Register read-back
  output logic [7:0]  wdog_count,
  output logic [7:0]  timer_ctrl_status,
  output logic [7:0]  wdog_reset_ctrl_status,
  // Reset and interrupt outputs
  output logic        chip_reset,
  output logic        sys_clear_out_pin_n,
  output logic        interval_irq
);

  localparam int RW = wdi_pkg::RST_CNT_W;

  // Pin pulse must end inside the internal reset
  if (wdi_pkg::OUT_RST_CYC > wdi_pkg::INT_RST_CYC) begin : g_chk
    $error("wdi_watchdog_unit: external pulse longer than internal");
  end

  logic [7:0]              count_r, count_nxt;
  logic                    mode_r, mode_nxt;
  logic                    run_r, run_nxt;
  logic [wdi_pkg::CKS_W-1:0] cks_r, cks_nxt;
  logic                    ovf_r, ovf_nxt;
  logic                    armed_r, armed_nxt;
  logic                    irq_r, irq_nxt;
  logic                    flag_r, flag_nxt;
  logic                    oe_r, oe_nxt;
  logic [RW-1:0]           int_left_r, int_left_nxt;
  logic [RW-1:0]           out_left_r, out_left_nxt;
  logic                    chip_r, chip_nxt;
  logic                    pin_n_r, pin_n_nxt;
  logic                    tick;
  logic                    wr_ok, wr_cnt, wr_ctl, wr_rcs;
  logic                    ovf_evt, wd_fire, hold_rst;
  logic [7:0]              wkey, wdat;

  wdi_prescaler #(
    .PRE_W (wdi_pkg::PRE_W)
  ) u_pre (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .run     (run_r & ~hold_rst),
    .sel     (cks_r),
    .tick    (tick)
  );

  assign wkey = cpu_wdata[15:8];
  assign wdat = cpu_wdata[7:0];
  assign hold_rst = (int_left_r != '0);
  assign wr_ok  = cpu_wr & cpu_wr_word;
  assign wr_cnt = wr_ok & ~cpu_wr_rst_reg & (wkey == wdi_pkg::KEY_COUNT);
  assign wr_ctl = wr_ok & ~cpu_wr_rst_reg & (wkey == wdi_pkg::KEY_CTRL);
  assign wr_rcs = wr_ok & cpu_wr_rst_reg;
  // Overflow is a wrap from FF on a tick
  assign ovf_evt = run_r & tick & (count_r == 8'hFF) & ~wr_cnt & ~hold_rst;
  // Cause only with mode and run set
  assign wd_fire = ovf_evt & mode_r & run_r;

  // Timer group
  always_comb begin
    count_nxt = count_r;
    mode_nxt  = mode_r;
    run_nxt   = run_r;
    cks_nxt   = cks_r;
    ovf_nxt   = ovf_r;
    armed_nxt = armed_r;
    if (cpu_rd_ctrl && ovf_r) begin
      armed_nxt = 1'b1;
    end
    // Mode, run and divider select written
    if (wr_ctl) begin
      mode_nxt = wdat[wdi_pkg::CTL_MODE_BIT];
      run_nxt  = wdat[wdi_pkg::CTL_RUN_BIT];
      cks_nxt  = wdat[wdi_pkg::CTL_CKS_LSB +: wdi_pkg::CKS_W];
      if (!wdat[wdi_pkg::CTL_OVF_BIT] && armed_r) begin
        ovf_nxt = 1'b0;
      end
      armed_nxt = 1'b0;
    end
    if (wr_cnt) begin
      count_nxt = wdat;
    end else if (run_r && tick) begin
      count_nxt = count_r + 8'h01;
    end
    if (!run_nxt) begin
      count_nxt = wdi_pkg::COUNT_RST;
    end
    // Flag set on the overflow cycle
    if (ovf_evt) begin
      ovf_nxt = 1'b1;
    end
    // Internal reset clears the timer state
    if (hold_rst) begin
      count_nxt = wdi_pkg::COUNT_RST;
      mode_nxt  = 1'b0;
      run_nxt   = 1'b0;
      cks_nxt   = wdi_pkg::CKS_RST;
      ovf_nxt   = 1'b0;
      armed_nxt = 1'b0;
    end
    // Interval request from flag and mode
    irq_nxt = ovf_nxt & ~mode_nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_r <= wdi_pkg::COUNT_RST;
      mode_r  <= 1'b0;
      run_r   <= 1'b0;
      cks_r   <= wdi_pkg::CKS_RST;
      ovf_r   <= 1'b0;
      armed_r <= 1'b0;
      irq_r   <= 1'b0;
    end else if (ce) begin
      count_r <= count_nxt;
      mode_r  <= mode_nxt;
      run_r   <= run_nxt;
      cks_r   <= cks_nxt;
      ovf_r   <= ovf_nxt;
      armed_r <= armed_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // Reset group
  always_comb begin
    flag_nxt     = flag_r;
    oe_nxt       = oe_r;
    int_left_nxt = int_left_r;
    out_left_nxt = out_left_r;
    if (wr_rcs && wkey == wdi_pkg::KEY_CTRL &&
        wdat == wdi_pkg::FLAG_CLR_DATA) begin
      flag_nxt = 1'b0;
    end
    if (wr_rcs && wkey == wdi_pkg::KEY_COUNT) begin
      oe_nxt = wdat[wdi_pkg::RCS_OE_BIT];
    end
    // Overflow sets cause flag, set wins
    if (wd_fire) begin
      flag_nxt = 1'b1;
    end
    if (wd_fire) begin
      int_left_nxt = RW'(wdi_pkg::INT_RST_CYC);
    end else if (int_left_r != '0) begin
      int_left_nxt = int_left_r - 1'b1;
    end
    // Only when out enable is set
    if (wd_fire && oe_r) begin
      out_left_nxt = RW'(wdi_pkg::OUT_RST_CYC);
    end else if (out_left_r != '0) begin
      out_left_nxt = out_left_r - 1'b1;
    end
    chip_nxt  = (int_left_nxt != '0);
    pin_n_nxt = (out_left_nxt == '0);
  end

  always_ff @(posedge clk_sys) begin
    // Pin reset drives the same request
    if (rst) begin
      flag_r     <= 1'b0;
      oe_r       <= 1'b0;
      int_left_r <= '0;
      out_left_r <= '0;
      chip_r     <= 1'b1;
      pin_n_r    <= 1'b1;
    end else if (ce) begin
      flag_r     <= flag_nxt;
      oe_r       <= oe_nxt;
      int_left_r <= int_left_nxt;
      out_left_r <= out_left_nxt;
      chip_r     <= chip_nxt;
      pin_n_r    <= pin_n_nxt;
    end
  end

  assign wdog_count = count_r;
  assign timer_ctrl_status =
    {ovf_r, mode_r, run_r, wdi_pkg::CTL_RSV_ONES, cks_r};
  assign wdog_reset_ctrl_status = {flag_r, oe_r, wdi_pkg::RCS_RSV_ONES};
  assign chip_reset = chip_r;
  assign sys_clear_out_pin_n = pin_n_r;
  // Request stands while overflow flag is set and mode is clear
  assign interval_irq = irq_r;

  // Helper counters of reset pulse lengths
  logic [RW-1:0] int_len_h, out_len_h;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_len_h <= '0;
      out_len_h <= '0;
    end else if (ce) begin
      int_len_h <= chip_r ? int_len_h + 1'b1 : '0;
      out_len_h <= !pin_n_r ? out_len_h + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  int_len_a: assert property (
    $fell(chip_r) && !$past(rst, 2)
    |-> int_len_h == RW'(wdi_pkg::INT_RST_STATES))
    else $error("internal reset length wrong");

  out_len_a: assert property (
    $rose(pin_n_r) && !$past(rst)
    |-> out_len_h == RW'(wdi_pkg::OUT_RST_STATES))
    else $error("external reset length wrong");

  pin_idle_a: assert property (
    !oe_r && !chip_r |-> pin_n_r)
    else $error("external reset while out enable clear");

  out_gate_a: assert property (
    $fell(pin_n_r) |-> $past(oe_r) && chip_r)
    else $error("external reset without out enable");

  pin_prio_a: assert property (
    $past(rst) |-> !flag_r && int_left_r == '0 && pin_n_r)
    else $error("pin reset did not win");

  flag_cause_a: assert property (
    $rose(flag_r) |-> ovf_r && mode_r && run_r && chip_r)
    else $error("cause flag set without watchdog overflow");

  flag_keep_a: assert property (
    wd_fire && ce ##1 ce |=> !ovf_r && flag_r)
    else $error("internal reset did not clear overflow only");

  ovf_set_a: assert property (
    ovf_evt && ce |=> ovf_r && (mode_r ? chip_r : interval_irq))
    else $error("overflow flag not set on overflow");

  irq_flag_a: assert property (
    interval_irq == (ovf_r && !mode_r))
    else $error("interval request does not follow flag");

  wr_wins_a: assert property (
    wr_cnt && ce && !hold_rst && run_nxt |=> count_r == $past(wdat))
    else $error("counter write lost to increment");

  halt_zero_a: assert property (
    !run_r |-> count_r == 8'h00)
    else $error("halted counter not zero");

  count_wrap_a: assert property (
    ovf_evt && ce |=> count_r == 8'h00)
    else $error("counter did not wrap to zero");

  ce_hold_a: assert property (
    !ce |=> $stable(count_r) && $stable(int_left_r) && $stable(ovf_r))
    else $error("state moved while clock enable low");

  byte_ign_a: assert property (
    cpu_wr && !cpu_wr_word && ce && !cpu_rd_ctrl && !hold_rst && !tick
    |=> $stable(mode_r) && $stable(run_r) && $stable(oe_r))
    else $error("byte write changed a register");

  wd_fire_c: cover property (wd_fire);
  irq_c:     cover property ($rose(interval_irq));
  out_c:     cover property ($fell(pin_n_r));
  flag_clr_c: cover property ($fell(flag_r));
  ce_hold_c: cover property (!ce ##1 ce);

endmodule

// ==== inc/wdi_pkg.sv ====
// Purpose: Shared constants of the watchdog and interval timer
// Assumes: One state of the timer equals one clk_sys cycle
// Notes:   Timing counts are derived from times in states
package wdi_pkg;

  // Widths
  localparam int CNT_W = 8;
  localparam int PRE_W = 12;
  localparam int CKS_W = 3;
  localparam int NUM_DIV = 8;

  // Write keys in the upper byte of a word write
  localparam logic [7:0] KEY_COUNT = 8'h5A;
  localparam logic [7:0] KEY_CTRL  = 8'hA5;
  localparam logic [7:0] FLAG_CLR_DATA = 8'h00;

  // Field positions of the timer control and status byte
  localparam int CTL_OVF_BIT  = 7;
  localparam int CTL_MODE_BIT = 6;
  localparam int CTL_RUN_BIT  = 5;
  localparam int CTL_CKS_LSB  = 0;

  // Field positions of the reset control and status byte
  localparam int RCS_FLAG_BIT = 7;
  localparam int RCS_OE_BIT   = 6;

  // Reserved bits that read as one
  localparam logic [1:0] CTL_RSV_ONES = 2'h3;
  localparam logic [5:0] RCS_RSV_ONES = 6'h3F;

  // Reset values
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [2:0] CKS_RST   = 3'h0;

  // Divider exponents: /2 /32 /64 /128 /256 /512 /2048 /4096
  localparam int DIV_LOG2 [0:NUM_DIV-1] = '{1, 5, 6, 7, 8, 9, 11, 12};

  // Timing: one state is one clock period
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int STATE_PS       = CLK_PERIOD_PS;
  localparam int INT_RST_STATES = 518;
  localparam int OUT_RST_STATES = 132;
  localparam int INT_RST_CYC =
    (INT_RST_STATES * STATE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OUT_RST_CYC =
    (OUT_RST_STATES * STATE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_CNT_W = $clog2(INT_RST_CYC + 1);

endpackage

// ==== design/wdi_prescaler.sv ====
// Purpose: Run-gated prescaler with selectable count tick
// Assumes: Synchronous active-high reset, clock enable freezes state
// Notes:   Held at zero while the timer is halted
`timescale 1ns/1ps
module wdi_prescaler #(
  parameter int PRE_W = wdi_pkg::PRE_W
) (
  // Clock and reset
  input  logic                     clk_sys,
  input  logic                     rst,
  input  logic                     ce,
  // Control
  input  logic                     run,
  input  logic [wdi_pkg::CKS_W-1:0] sel,
  // Count tick
  output logic                     tick
);

  logic [PRE_W-1:0]            pre_r;
  logic [PRE_W-1:0]            pre_nxt;
  logic [wdi_pkg::NUM_DIV-1:0] hit;

  if (PRE_W < wdi_pkg::DIV_LOG2[wdi_pkg::NUM_DIV-1]) begin : g_chk
    $error("wdi_prescaler: PRE_W too small for the largest divisor");
  end

  // Tick when the low bits of the prescaler are all ones
  for (genvar i = 0; i < wdi_pkg::NUM_DIV; i++) begin : g_hit
    assign hit[i] = &pre_r[wdi_pkg::DIV_LOG2[i]-1:0];
  end

  assign tick = run & hit[sel];

  always_comb begin
    pre_nxt = run ? pre_r + 1'b1 : '0;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre_r <= '0;
    end else if (ce) begin
      pre_r <= pre_nxt;
    end
  end

endmodule

// ==== test/wdi_cpu_model.sv ====
// Purpose: Software side of the timer, issues keyed CPU writes
// Assumes: Signals change at the falling edge of clk_sys
// Notes:   Idle data bus shows a changing pattern
`timescale 1ns/1ps
module wdi_cpu_model (
  // Clock
  input  logic        clk_sys,
  // CPU strobes and data
  output logic        cpu_wr,
  output logic        cpu_wr_word,
  output logic        cpu_wr_rst_reg,
  output logic [15:0] cpu_wdata,
  output logic        cpu_rd_ctrl
);
  logic [15:0] idle_pat;
  initial begin
    cpu_wr = 1'b0;
    cpu_wr_word = 1'b0;
    cpu_wr_rst_reg = 1'b0;
    cpu_rd_ctrl = 1'b0;
    idle_pat = 16'hC3A5;
    cpu_wdata = idle_pat;
  end
  task automatic wr(input logic rr, input logic wd,
                    input logic [7:0] key, input logic [7:0] dat);
    @(negedge clk_sys);
    cpu_wr = 1'b1;
    cpu_wr_word = wd;
    cpu_wr_rst_reg = rr;
    cpu_wdata = {key, dat};
    @(negedge clk_sys);
    cpu_wr = 1'b0;
    idle_pat = ~idle_pat;
    cpu_wdata = idle_pat;
  endtask
  task automatic rd_ctrl;
    @(negedge clk_sys);
    cpu_rd_ctrl = 1'b1;
    @(negedge clk_sys);
    cpu_rd_ctrl = 1'b0;
  endtask
endmodule

// ==== test/wdi_watchdog_unit_bench.sv ====
// Purpose: Self-checking bench of the watchdog and interval timer
// Assumes: One state is one clk_sys cycle
// Notes:   Reset pulse widths are checked from a queue
`timescale 1ns/1ps
module wdi_watchdog_unit_bench;
  logic        clk_sys, rst, ce, cpu_wr, cpu_wr_word, cpu_wr_rst_reg;
  logic [15:0] cpu_wdata;
  logic        cpu_rd_ctrl, chip_reset, sys_clear_out_pin_n, interval_irq;
  logic [7:0]  wdog_count, timer_ctrl_status, wdog_reset_ctrl_status;
  logic [7:0]  rnd;
  logic        armed;
  integer      seed;
  int          fail_count, n_compared, rst_len, pin_len;
  int          rst_q[$];
  int          pin_q[$];

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  wdi_cpu_model cpu (.clk_sys(clk_sys), .cpu_wr(cpu_wr),
    .cpu_wr_word(cpu_wr_word), .cpu_wr_rst_reg(cpu_wr_rst_reg),
    .cpu_wdata(cpu_wdata), .cpu_rd_ctrl(cpu_rd_ctrl));

  wdi_watchdog_unit uut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .cpu_wr(cpu_wr), .cpu_wr_word(cpu_wr_word),
    .cpu_wr_rst_reg(cpu_wr_rst_reg), .cpu_wdata(cpu_wdata),
    .cpu_rd_ctrl(cpu_rd_ctrl), .wdog_count(wdog_count),
    .timer_ctrl_status(timer_ctrl_status),
    .wdog_reset_ctrl_status(wdog_reset_ctrl_status),
    .chip_reset(chip_reset), .sys_clear_out_pin_n(sys_clear_out_pin_n),
    .interval_irq(interval_irq));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wait_for(input logic on_irq, input logic val);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(negedge clk_sys);
      if ((on_irq ? interval_irq : chip_reset) === val)
        break;
    end
    if (i == 2000) begin
      fail_count++;
      $display("Error %0t: wait timed out", $time);
      test_done();
    end
  endtask

  // Measures reset pulses and takes the oldest expected width
  always @(posedge clk_sys) begin
    if (rst || !armed) begin
      rst_len = 0;
      pin_len = 0;
    end else begin
      if (chip_reset === 1'b1)
        rst_len++;
      else if (rst_len > 0) begin
        check(16'(rst_len), 16'(rst_q.size() ? rst_q.pop_front() : 0));
        rst_len = 0;
      end
      if (sys_clear_out_pin_n === 1'b0)
        pin_len++;
      else if (pin_len > 0) begin
        check(16'(pin_len), 16'(pin_q.size() ? pin_q.pop_front() : 0));
        pin_len = 0;
      end
    end
  end

  initial begin
    seed = 32'h9AD6C84E;
    rst = 1'b1;
    ce = 1'b1;
    armed = 1'b0;
    fail_count = 0;
    n_compared = 0;
    repeat (12) @(negedge clk_sys);
    check({chip_reset, sys_clear_out_pin_n, interval_irq}, 16'h6);
    rst = 1'b0;
    @(negedge clk_sys);
    armed = 1'b1;
    check({wdog_count, timer_ctrl_status}, 16'h0018);
    check(wdog_reset_ctrl_status, 16'h3F);
    cpu.wr(1'b0, 1'b0, 8'hA5, 8'h20);
    cpu.wr(1'b0, 1'b1, 8'h3C, 8'h20);
    check(timer_ctrl_status, 16'h18);
    cpu.wr(1'b0, 1'b1, 8'hA5, 8'h27);
    rnd = 8'($random(seed)) & 8'h7F;
    cpu.wr(1'b0, 1'b1, 8'h5A, rnd);
    check(wdog_count, rnd);
    for (int k = 0; k < 8; k++) begin
      cpu.wr(1'b0, 1'b1, 8'hA5, 8'h00);
      check(wdog_count, 16'h0);
      cpu.wr(1'b0, 1'b1, 8'hA5, 8'h20 | 8'(k));
      repeat ((1 << wdi_pkg::DIV_LOG2[k]) + 1) @(negedge clk_sys);
      check(wdog_count, 16'h1);
    end
    $display("test keys and divisors done");
    cpu.wr(1'b0, 1'b1, 8'hA5, 8'h00);
    cpu.wr(1'b0, 1'b1, 8'hA5, 8'h20);
    cpu.wr(1'b0, 1'b1, 8'h5A, 8'hFE);
    wait_for(1'b1, 1'b1);
    check({wdog_count, timer_ctrl_status}, 16'h00B8);
    check(wdog_reset_ctrl_status, 16'h3F);
    cpu.rd_ctrl();
    cpu.wr(1'b0, 1'b1, 8'hA5, 8'h20);
    check({interval_irq, timer_ctrl_status}, 16'h38);
    rnd = wdog_count;
    ce = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(wdog_count, rnd);
    ce = 1'b1;
    $display("test interval done");
    for (int oe = 1; oe >= 0; oe--) begin
      cpu.wr(1'b1, 1'b1, 8'h5A, oe ? 8'h40 : 8'h00);
      rst_q.push_back(wdi_pkg::INT_RST_STATES);
      if (oe)
        pin_q.push_back(wdi_pkg::OUT_RST_STATES);
      cpu.wr(1'b0, 1'b1, 8'hA5, 8'h60);
      cpu.wr(1'b0, 1'b1, 8'h5A, 8'hFF);
      wait_for(1'b0, 1'b1);
      check(timer_ctrl_status, 16'hF8);
      check(sys_clear_out_pin_n, 16'(oe == 0));
      wait_for(1'b0, 1'b0);
      check(timer_ctrl_status, 16'h18);
      check(wdog_reset_ctrl_status, oe ? 16'hFF : 16'hBF);
      cpu.wr(1'b1, 1'b1, 8'hA5, 8'h00);
      check(wdog_reset_ctrl_status, oe ? 16'h7F : 16'h3F);
    end
    repeat (3) @(negedge clk_sys);
    check(16'(rst_q.size() + pin_q.size()), 16'h0);
    $display("test watchdog done");
    cpu.wr(1'b1, 1'b1, 8'h5A, 8'h40);
    cpu.wr(1'b0, 1'b1, 8'hA5, 8'h60);
    cpu.wr(1'b0, 1'b1, 8'h5A, 8'hFF);
    wait_for(1'b0, 1'b1);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    check({chip_reset, sys_clear_out_pin_n, 8'h00}, 16'h300);
    check(wdog_reset_ctrl_status, 16'h3F);
    rst = 1'b0;
    @(negedge clk_sys);
    check({chip_reset, timer_ctrl_status}, 16'h018);
    $display("test pin reset done");
    test_done();
  end
endmodule
